// ==== rtl/ssq_pkg.sv ====
package ssq_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MASTER_OSC_KHZ = 38400;
  localparam int FAST_TIME_US = 4000;
  localparam int MED_TIME_US = 16700;
  localparam int SLOW_TIME_US = 100000;
  localparam int FAST_CYCLES = FAST_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int MED_CYCLES = MED_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int SLOW_CYCLES = SLOW_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);

  // ---------------------------------------------------------------
  // register map (byte offsets) and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] DIVISOR_OFS = 8'h08;
  localparam logic [7:0] ITF_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] RESULT_OFS = 8'h14;
  localparam logic [15:0] DIVISOR_RST = 16'h07a1;
  localparam logic [5:0] ITF_RST = 6'h28;
  localparam logic [5:0] ITF_MIN = 6'h01;
  localparam logic [5:0] ITF_MAX = 6'h18;

  // ---------------------------------------------------------------
  // divider thresholds and acquisition lengths
  // ---------------------------------------------------------------
  localparam logic [15:0] SYNC_HI_DIV = 16'h0020;
  localparam logic [15:0] FILT_LIM0 = 16'h0014;
  localparam logic [15:0] FILT_LIM1 = 16'h00c8;
  localparam logic [15:0] FILT_LIM2 = 16'h07d0;
  localparam logic [3:0] CONV_NORM = 4'h6;
  localparam logic [3:0] CONV_QUICK = 4'h5;
  localparam logic [3:0] CONV_SLOW = 4'h8;

  typedef enum logic [1:0] {
    SSQ_FAST = 2'h0,
    SSQ_MED = 2'h1,
    SSQ_SLOW = 2'h2
  } ssq_rate_type;

  typedef enum logic [2:0] {
    SSQ_IDLE = 3'h0,
    SSQ_SYNC = 3'h1,
    SSQ_INTEG = 3'h3,
    SSQ_DEINT = 3'h2,
    SSQ_HOLD = 3'h6
  } ssq_fsm_type;

  typedef struct packed {
    ssq_fsm_type st;
    logic [15:0] step_cnt;
    logic [5:0] addr;
    logic [7:0] test_sample;
    logic [7:0] ref_sample;
    logic [1:0] filt;
    logic period_pulse;
    logic [1:0] ref_phase;
    logic [3:0] conv_idx;
    logic [31:0] elapsed;
    logic [31:0] per_cnt;
    logic integ;
    logic deint;
    logic [23:0] count;
    logic [23:0] result;
    logic valid;
    ssq_rate_type rate;
    logic quick;
    logic single;
    logic [1:0] phase_cmd;
    logic [15:0] divisor;
    logic [5:0] itf;
    logic start_pend;
    logic rdy;
    logic slverr;
    logic [31:0] rdata;
  } ssq_state_type;

endpackage

// ==== rtl/ssq_top.sv ====
`timescale 1ns/1ps

module ssq_top #(
  parameter int FAST_CYC = ssq_pkg::FAST_CYCLES,
  parameter int MED_CYC = ssq_pkg::MED_CYCLES,
  parameter int SLOW_CYC = ssq_pkg::SLOW_CYCLES,
  parameter logic [15:0] DIV_RST = ssq_pkg::DIVISOR_RST
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zero_cross_detect_n,
  input wire logic integrator_overlevel_n,
  output logic [7:0] test_dac_data,
  output logic [7:0] ref_mdac_data,
  output logic [1:0] filter_select,
  output logic integrate_en,
  output logic deintegrate_en,
  output logic test_period_count_clock
);

  ssq_pkg::ssq_state_type r_reg;
  ssq_pkg::ssq_state_type r_next;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // quarter-wave table, offset binary around mid scale
  function automatic logic [7:0] sine_lut(input logic [5:0] a);
    logic [4:0] k;
    logic [7:0] m;
    k = a[4] ? 5'h10 - {1'b0, a[3:0]} : {1'b0, a[3:0]};
    case (k)
      5'h00: m = 8'h00;
      5'h01: m = 8'h0c;
      5'h02: m = 8'h19;
      5'h03: m = 8'h25;
      5'h04: m = 8'h31;
      5'h05: m = 8'h3c;
      5'h06: m = 8'h47;
      5'h07: m = 8'h51;
      5'h08: m = 8'h5a;
      5'h09: m = 8'h62;
      5'h0a: m = 8'h6a;
      5'h0b: m = 8'h70;
      5'h0c: m = 8'h75;
      5'h0d: m = 8'h7a;
      5'h0e: m = 8'h7d;
      5'h0f: m = 8'h7e;
      default: m = 8'h7f;
    endcase
    return a[5] ? 8'h80 - m : 8'h80 + m;
  endfunction

  // address decode used by both the read and the write path
  function automatic logic is_mapped(input logic [7:0] a);
    return a == ssq_pkg::CTRL_OFS || a == ssq_pkg::CMD_OFS ||
      a == ssq_pkg::DIVISOR_OFS || a == ssq_pkg::ITF_OFS ||
      a == ssq_pkg::STATUS_OFS || a == ssq_pkg::RESULT_OFS;
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic step;
    logic [31:0] plen;
    logic [31:0] target;
    logic [31:0] e1;
    logic cont;
    logic [3:0] last;
    logic [3:0] nidx;
    logic done;
    step = 1'b0;
    plen = '0;
    target = '0;
    e1 = '0;
    cont = 1'b0;
    last = '0;
    nidx = '0;
    done = 1'b0;
    r_next = r_reg;

    // divider: one table step every divisor clocks, 64 steps per period
    step = r_reg.step_cnt >= r_reg.divisor - 16'h0001;
    r_next.step_cnt = step ? 16'h0000 : r_reg.step_cnt + 16'h0001;
    if (step) begin
      r_next.addr = r_reg.addr + 6'h01;
    end
    r_next.test_sample = sine_lut(r_reg.addr);
    // xor on bit5 (f) and bit4 (2f) turns the reference by 90/180/270
    r_next.ref_sample = sine_lut(r_reg.addr ^ {r_reg.ref_phase, 4'h0});

    // smoothing filter band from the step divisor
    if (r_reg.divisor < ssq_pkg::FILT_LIM0) begin
      r_next.filt = 2'h3;
    end else if (r_reg.divisor < ssq_pkg::FILT_LIM1) begin
      r_next.filt = 2'h2;
    end else if (r_reg.divisor < ssq_pkg::FILT_LIM2) begin
      r_next.filt = 2'h1;
    end else begin
      r_next.filt = 2'h0;
    end

    // period clock: full period at high rates, 1/32 period when slow
    if (r_reg.divisor < ssq_pkg::SYNC_HI_DIV) begin
      r_next.period_pulse = step && r_reg.addr == 6'h3f;
    end else begin
      r_next.period_pulse = step && r_reg.addr[0];
    end

    // integration target in clocks; factor is held in quarters
    plen = {10'h000, r_reg.divisor, 6'h00};
    case (r_reg.rate)
      ssq_pkg::SSQ_FAST: target = 32'((FAST_CYC * int'(r_reg.itf)) / 4);
      ssq_pkg::SSQ_MED: target = 32'((MED_CYC * int'(r_reg.itf)) / 4);
      default: target = 32'(SLOW_CYC);
    endcase
    e1 = r_reg.elapsed + 32'h0000_0001;
    if (r_reg.rate == ssq_pkg::SSQ_FAST) begin
      // nearest: take one more period while it lands closer to target
      cont = ({e1[30:0], 1'b0} + plen) < {target[30:0], 1'b0};
    end else begin
      cont = (e1 + plen) <= target;
    end

    // acquisition length
    if (r_reg.single) begin
      last = 4'h0;
    end else if (r_reg.rate == ssq_pkg::SSQ_SLOW) begin
      last = ssq_pkg::CONV_SLOW - 4'h1;
    end else if (r_reg.quick) begin
      last = ssq_pkg::CONV_QUICK - 4'h1;
    end else begin
      last = ssq_pkg::CONV_NORM - 4'h1;
    end
    nidx = r_reg.conv_idx + 4'h1;

    // apb: data registered in setup, answered in the access cycle
    r_next.rdy = psel && !penable;
    if (psel && !penable) begin
      r_next.slverr = !is_mapped(paddr);
      case (paddr)
        ssq_pkg::CTRL_OFS: r_next.rdata = {26'h0, r_reg.phase_cmd, r_reg.single,
          r_reg.quick, r_reg.rate};
        ssq_pkg::DIVISOR_OFS: r_next.rdata = {16'h0000, r_reg.divisor};
        ssq_pkg::ITF_OFS: r_next.rdata = {26'h0, r_reg.itf};
        ssq_pkg::STATUS_OFS: r_next.rdata = {19'h0, r_reg.st, r_reg.ref_phase,
          r_reg.conv_idx, r_reg.deint, r_reg.integ, r_reg.valid,
          r_reg.st != ssq_pkg::SSQ_IDLE};
        ssq_pkg::RESULT_OFS: r_next.rdata = {8'h00, r_reg.result};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end
    done = psel && penable && r_reg.rdy;
    if (done && pwrite) begin
      // mode fields are frozen while an acquisition runs
      if (paddr == ssq_pkg::CTRL_OFS && r_reg.st == ssq_pkg::SSQ_IDLE) begin
        r_next.rate = ssq_pkg::ssq_rate_type'(pwdata[1:0]);
        r_next.quick = pwdata[2];
        r_next.single = pwdata[3];
        r_next.phase_cmd = pwdata[5:4];
      end
      if (paddr == ssq_pkg::DIVISOR_OFS) begin
        r_next.divisor = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
      if (paddr == ssq_pkg::ITF_OFS) begin
        if (pwdata[5:0] < ssq_pkg::ITF_MIN || pwdata[31:6] != 26'h0) begin
          r_next.itf = (pwdata[31:6] != 26'h0) ? ssq_pkg::ITF_MAX : ssq_pkg::ITF_MIN;
        end else if (pwdata[5:0] > ssq_pkg::ITF_MAX) begin
          r_next.itf = ssq_pkg::ITF_MAX;
        end else begin
          r_next.itf = pwdata[5:0];
        end
      end
    end
    // reading the result releases the hold
    if (done && !pwrite && paddr == ssq_pkg::RESULT_OFS) begin
      r_next.valid = 1'b0;
    end

    // conversion sequencer
    case (r_reg.st)
      ssq_pkg::SSQ_IDLE: begin
        if (r_reg.start_pend) begin
          r_next.start_pend = 1'b0;
          r_next.conv_idx = 4'h0;
          r_next.ref_phase = r_reg.single ? r_reg.phase_cmd : 2'h0;
          r_next.st = ssq_pkg::SSQ_SYNC;
        end
      end
      ssq_pkg::SSQ_SYNC: begin
        if (r_reg.period_pulse) begin
          r_next.integ = 1'b1;
          r_next.elapsed = 32'h0;
          r_next.per_cnt = 32'h0;
          r_next.st = ssq_pkg::SSQ_INTEG;
        end
      end
      ssq_pkg::SSQ_INTEG: begin
        r_next.elapsed = e1;
        r_next.per_cnt = r_reg.per_cnt + 32'h1;
        if (r_reg.deint) begin
          r_next.count = r_reg.count + 24'h1;
        end
        if (r_reg.deint && !zero_cross_detect_n) begin
          // ramp crossed zero while still sampling: conversion is over
          r_next.integ = 1'b0;
          r_next.deint = 1'b0;
          r_next.result = r_reg.count;
          r_next.valid = 1'b1;
          r_next.st = ssq_pkg::SSQ_HOLD;
        end else begin
          if (!r_reg.deint && !integrator_overlevel_n) begin
            r_next.deint = 1'b1;
            r_next.count = 24'h0;
          end
          if (r_reg.per_cnt == plen - 32'h1) begin
            r_next.per_cnt = 32'h0;
            if (!cont) begin
              r_next.integ = 1'b0;
              r_next.st = ssq_pkg::SSQ_DEINT;
              if (!r_reg.deint && integrator_overlevel_n) begin
                r_next.deint = 1'b1;
                r_next.count = 24'h0;
              end
            end
          end
        end
      end
      ssq_pkg::SSQ_DEINT: begin
        if (!zero_cross_detect_n) begin
          r_next.deint = 1'b0;
          r_next.result = r_reg.count;
          r_next.valid = 1'b1;
          r_next.st = ssq_pkg::SSQ_HOLD;
        end else begin
          r_next.count = r_reg.count + 24'h1;
        end
      end
      ssq_pkg::SSQ_HOLD: begin
        // result stays frozen; next conversion waits for the read
        if (!r_reg.valid) begin
          if (r_reg.conv_idx >= last) begin
            r_next.st = ssq_pkg::SSQ_IDLE;
          end else begin
            r_next.conv_idx = nidx;
            r_next.ref_phase = nidx[2:1];
            r_next.st = ssq_pkg::SSQ_SYNC;
          end
        end
      end
      default: begin
        r_next.st = ssq_pkg::SSQ_IDLE;
        r_next.integ = 1'b0;
        r_next.deint = 1'b0;
      end
    endcase

    // start command: a write in the consuming cycle is kept
    if (done && pwrite && paddr == ssq_pkg::CMD_OFS && pwdata[0]) begin
      r_next.start_pend = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.divisor <= DIV_RST;
      r_reg.itf <= ssq_pkg::ITF_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops, except pslverr which is slverr gated by rdy
  assign prdata = r_reg.rdata;
  assign pready = r_reg.rdy;
  assign pslverr = r_reg.slverr && r_reg.rdy;
  assign test_dac_data = r_reg.test_sample;
  assign ref_mdac_data = r_reg.ref_sample;
  assign filter_select = r_reg.filt;
  assign integrate_en = r_reg.integ;
  assign deintegrate_en = r_reg.deint;
  assign test_period_count_clock = r_reg.period_pulse;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_step_advance;
    @(posedge clk) disable iff (srst)
      (r_reg.step_cnt >= r_reg.divisor - 16'h0001) |=> r_reg.addr == $past(r_reg.addr) + 6'h01;
  endproperty
  a_step_advance: assert property (p_step_advance) else $error("table address missed a step");

  property p_test_peak;
    @(posedge clk) disable iff (srst)
      r_reg.addr == 6'h10 |=> test_dac_data == 8'hff;
  endproperty
  a_test_peak: assert property (p_test_peak) else $error("test sample wrong at peak");

  property p_ref_inverse;
    @(posedge clk) disable iff (srst)
      (r_reg.addr == 6'h10 && r_reg.ref_phase == 2'h2) |=> ref_mdac_data == 8'h01;
  endproperty
  a_ref_inverse: assert property (p_ref_inverse) else $error("180 degree reference wrong");

  property p_count_gate;
    @(posedge clk) disable iff (srst)
      (r_reg.count != $past(r_reg.count) && r_reg.count != 24'h0) |-> $past(r_reg.deint);
  endproperty
  a_count_gate: assert property (p_count_gate) else $error("counter ran outside deintegration");

  property p_overlevel;
    @(posedge clk) disable iff (srst)
      (r_reg.st == ssq_pkg::SSQ_INTEG && !r_reg.deint && !integrator_overlevel_n)
        |=> deintegrate_en ##0 r_reg.count == 24'h0;
  endproperty
  a_overlevel: assert property (p_overlevel) else $error("overlevel did not start deintegration");

  property p_sync;
    @(posedge clk) disable iff (srst)
      (r_reg.st == ssq_pkg::SSQ_SYNC && r_reg.period_pulse) |=> integrate_en;
  endproperty
  a_sync: assert property (p_sync) else $error("integration not started on sync");

  property p_result_hold;
    @(posedge clk) disable iff (srst)
      (r_reg.st == ssq_pkg::SSQ_HOLD && r_reg.valid) |=> $stable(r_reg.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved before read");

  property p_phase_stable;
    @(posedge clk) disable iff (srst)
      (integrate_en || deintegrate_en) |=> $stable(r_reg.ref_phase);
  endproperty
  a_phase_stable: assert property (p_phase_stable) else $error("phase changed mid conversion");

  property p_phase_seq;
    @(posedge clk) disable iff (srst)
      (integrate_en && !r_reg.single) |-> r_reg.ref_phase == r_reg.conv_idx[2:1];
  endproperty
  a_phase_seq: assert property (p_phase_seq) else $error("sequence phase wrong");

  property p_quick_len;
    @(posedge clk) disable iff (srst)
      (r_reg.st == ssq_pkg::SSQ_SYNC && r_reg.quick && !r_reg.single &&
        r_reg.rate != ssq_pkg::SSQ_SLOW) |-> r_reg.conv_idx <= 4'h4;
  endproperty
  a_quick_len: assert property (p_quick_len) else $error("quick acquisition too long");

endmodule

// ==== testbench/sine_ref_dual_slope_sequencer_tb.sv ====
`timescale 1ns/1ps

module sine_ref_dual_slope_sequencer_tb;
  // short integration targets keep the run brief
  localparam int FC = 1000;
  localparam int MC = 1500;
  localparam int SC = 2000;
  localparam int DIV = 2;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, zc_n, ovl_n, integ, deint, pulse;
  logic [7:0] tdac, rdac;
  logic [7:0] zc_dly = 8'h0a;
  logic [7:0] ovl_at = 8'h00;
  logic [1:0] filt;
  int n_mismatch = 0, tests_run = 0, seed = 17688, cyc = 0;
  int icnt = 0, dcnt = 0, ocnt = 0, gap = 0, lastp = 0, nosync = 0, neq = 0;
  logic iq = 1'b0, dq = 1'b0, pq = 1'b0, eqchk = 1'b0;
  // sine model state: cycles since sync tick, table step, expected phase
  int sj = 0, sa = 0, nsin = 0, cph = 0;
  logic sinechk = 1'b0;
  int wv[3] = '{0, 63, 5};
  int ev[3] = '{1, 24, 5};
  int dv[6] = '{19, 20, 199, 200, 1999, 2000};
  int fv[6] = '{3, 2, 2, 1, 1, 0};

  always #4 clk = ~clk;

  // independent sine model: 64 steps, offset binary around 0x80
  function int sine_ref(input int a);
    return 128 + int'(127.0 * $sin(6.283185307179586 * a / 64.0));
  endfunction

  ssq_top #(
    .FAST_CYC(FC),
    .MED_CYC(MC),
    .SLOW_CYC(SC),
    .DIV_RST(16'h07a1)
  ) uut (
    .clk(clk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .zero_cross_detect_n(zc_n),
    .integrator_overlevel_n(ovl_n),
    .test_dac_data(tdac),
    .ref_mdac_data(rdac),
    .filter_select(filt),
    .integrate_en(integ),
    .deintegrate_en(deint),
    .test_period_count_clock(pulse)
  );

  ssq_detector_model det (
    .clk(clk),
    .integrate_en(integ),
    .deintegrate_en(deint),
    .zc_delay(zc_dly),
    .ovl_at(ovl_at),
    .zero_cross_detect_n(zc_n),
    .integrator_overlevel_n(ovl_n)
  );

  // ----------------------------------------
  // pin-level reference counters
  // ----------------------------------------
  // counters restart on their own edges, so no clear can race a sync tick
  always @(posedge clk) begin
    cyc++;
    if (integ && !iq && pq !== 1'b1) nosync++;
    icnt = integ ? (iq ? icnt + 1 : 1) : icnt;
    if (integ && !iq) ocnt = 0;
    if (integ && deint) ocnt++;
    if (deint && !dq) dcnt = 0;
    if (deint && zc_n) dcnt++;
    if (pulse) begin
      gap = cyc - lastp;
      lastp = cyc;
    end
    if (eqchk && integ && rdac !== tdac) neq++;
    // table step of the sample seen here; samples lag the address by one clock
    sj = pulse ? 0 : sj + 1;
    sa = (sj + 64 * DIV - 1) / DIV % 64;
    if (sinechk && tdac !== 8'(sine_ref(sa))) nsin++;
    if (sinechk && integ && rdac !== 8'(sine_ref(sa ^ (cph * 16)))) nsin++;
    iq = integ;
    dq = deint;
    pq = pulse;
  end

  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t reg got %h want %h", $time, got, exp);
    end
  endtask

  task chk_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD %0t count got %0d want %0d", $time, got, exp);
    end
  endtask

  // entered just after an edge; leaves one idle edge after release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    @(posedge clk);
    while (pready !== 1'b1 && t < 20) begin
      t++;
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    if (t >= 20) begin
      n_mismatch++;
      $display("BAD %0t bus gave no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // whole periods of integration, worked in quarter units of the factor
  function int periods(input int r, input int f);
    int c, p, n, t;
    c = (r == 0) ? FC : ((r == 1) ? MC : SC);
    p = 256 * DIV;
    t = (r == 2) ? c * 4 : c * f;
    n = t / p;
    if (r == 0 && t - n * p > (n + 1) * p - t) n++;
    return (n < 1) ? 1 : n;
  endfunction

  task acq(input int r, input int q, input int sg, input int ph, input int ovl);
    int f, n, k, t;
    logic [1:0] eph;
    f = 1 + $unsigned($random(seed)) % 8;
    eqchk = (sg != 0 && ph == 0);
    ovl_at <= 8'(ovl);
    apb(1'b1, 8'h0c, 32'(f));
    apb(1'b1, 8'h00, 32'(r + 4 * q + 8 * sg + 16 * ph));
    n = (sg != 0) ? 1 : ((r == 2) ? 8 : ((q != 0) ? 5 : 6));
    cph = (sg != 0) ? ph : 0;
    apb(1'b1, 8'h04, 32'h1);
    for (k = 0; k < n; k++) begin
      zc_dly <= 8'(5 + $unsigned($random(seed)) % 30);
      t = 0;
      do begin
        apb(1'b0, 8'h10, 32'h0);
        t++;
      end while (rd[1] !== 1'b1 && t < 5000);
      eph = (sg != 0) ? 2'(ph) : 2'(k / 2);
      chk_reg({30'h0, rd[9:8]}, {30'h0, eph});
      chk_cnt(icnt, periods(r, f) * 64 * DIV);
      chk_cnt(nosync, 0);
      chk_cnt((ocnt > 0) ? 1 : 0, (ovl != 0) ? 1 : 0);
      apb(1'b0, 8'h14, 32'h0);
      chk_reg(rd, 32'(dcnt));
      // next integration cannot start before the next edge, so this is in time
      cph = (sg != 0) ? ph : (k + 1) / 2;
      apb(1'b0, 8'h10, 32'h0);
      chk_reg({30'h0, rd[1:0]}, (k < n - 1) ? 32'h1 : 32'h0);
    end
  endtask

  task results;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    chk_reg(rd, 32'h28);
    apb(1'b0, 8'h18, 32'h0);
    chk_reg({31'h0, er}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h0c, 32'(wv[i]));
      apb(1'b0, 8'h0c, 32'h0);
      chk_reg(rd, 32'(ev[i]));
    end
    // band edges of the smoothing filter, one each side
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h08, 32'(dv[i]));
      repeat (2) @(posedge clk);
      chk_reg({30'h0, filt}, 32'(fv[i]));
    end
    apb(1'b1, 8'h08, 32'(DIV));
    repeat (300) @(posedge clk);
    chk_cnt(gap, 64 * DIV);
    sinechk = 1'b1;
    for (int p = 0; p < 4; p++) begin
      acq(0, 0, 1, p, 0);
    end
    acq(0, 0, 1, 0, 40);
    acq(0, 0, 0, 0, 0);
    acq(1, 0, 0, 0, 0);
    acq(0, 1, 0, 0, 0);
    acq(2, 0, 0, 0, 0);
    chk_cnt(neq, 0);
    chk_cnt(nsin, 0);
    results;
  end

  // cut a hang short well past the expected run length
  initial begin
    #760000;
    n_mismatch++;
    results;
  end
endmodule

// ==== testbench/ssq_detector_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------
// comparators of the dual-slope integrator
// ------------------------------------------
module ssq_detector_model (
  input wire logic clk,
  input wire logic integrate_en,
  input wire logic deintegrate_en,
  input wire logic [7:0] zc_delay,
  input wire logic [7:0] ovl_at,
  output logic zero_cross_detect_n,
  output logic integrator_overlevel_n
);
  int ic = 0;
  int dc = 0;

  initial zero_cross_detect_n = 1'b1;
  initial integrator_overlevel_n = 1'b1;

  // ramp reaches zero only once sampling is over, so never mid-integration
  always @(posedge clk) begin
    ic = integrate_en ? ic + 1 : 0;
    dc = (deintegrate_en && !integrate_en) ? dc + 1 : 0;
    zero_cross_detect_n <= !(dc != 0 && dc >= int'(zc_delay));
    integrator_overlevel_n <= !(ovl_at != 8'h00 && ic >= int'(ovl_at));
  end
endmodule
